//--- verilog/sdcr_ctrl.sv
// sdram host controller: wake sequence, refresh, access timing, request fifo
//
// Contract
// - after reset wait 100us, then give two auto refreshes before any access.
// - when the refresh period has lapsed, give the pair of auto refreshes again.
// - report that the clock may change only while stopped or in power-down.
// - only nops follow an auto refresh for the refresh cycle time.
// - at least one nop follows load mode register within the mode set delay.
// - precharge after a write waits 15ns past the last write data.
// - write recovery always holds at least one full clock.
// - after a page write, write recovery elapses before precharge.
// - precharge never comes before the row active minimum time since activate.
// - refresh keeps its interval while in power-down by leaving it when due.
`include "sdcr_params.svh"

// request buffer: flip-flop storage, honest full and empty
module sdcr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp, rp, next_wp, next_rp;
   logic push, pop;

   // pointers carry a wrap bit so full and empty differ
   always_comb
   begin
      in_ready = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
      out_valid = (wp != rp);
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wp = wp + (AW+1)'(push);
      next_rp = rp + (AW+1)'(pop);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         wp <= '0;
         rp <= '0;
      end
      else
      begin
         wp <= next_wp;
         rp <= next_rp;
      end
   end

   // storage has no reset; only written entries are ever read
   always_ff @(posedge core_clk)
   begin
      if (push)
         mem[wp[AW-1:0]] <= in_data;
   end

   assign out_data = mem[rp[AW-1:0]];
endmodule

// controller top
module sdcr_ctrl #(
   parameter int REF_CYC = `SDCR_REF_CYC,
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // user requests
   input wire logic req_valid,
   output logic req_ready,
   input wire sdcr_pkg::sdcr_req_s req,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic init_done,
   // power control
   input wire logic pd_req,
   input wire logic clk_stop_req,
   output logic clk_change_ok,
   // sdram pins
   output logic cke,
   output sdcr_pkg::sdcr_cmd_s cmd,
   output logic [1:0] ba,
   output logic [12:0] addr,
   output logic [15:0] dq_out,
   output logic dq_oe,
   input wire logic [15:0] dq_in
);
   localparam int RW = $clog2(REF_CYC + 1);
   sdcr_pkg::sdcr_req_s q_req, cur, next_cur;
   logic q_valid, q_ready;
   sdcr_pkg::sdcr_state_e state, next_state;
   logic [11:0] wait_cnt, next_wait;
   logic [RW-1:0] ref_cnt, next_ref_cnt;
   logic [3:0] act_age, next_act_age;
   logic [1:0] ref_left, next_ref_left;
   logic next_init, next_cke, next_oe, next_rd_valid;
   logic [`SDCR_CL-1:0] rd_pipe, next_rd_pipe;
   logic [15:0] next_dq, next_rd_data;
   sdcr_pkg::sdcr_cmd_s next_cmd;
   logic [1:0] next_ba;
   logic [12:0] next_addr;
   logic ref_due, ref_lapsed;

   sdcr_fifo #(.WIDTH($bits(sdcr_pkg::sdcr_req_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(req),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_req)
   );

   assign ref_due = (ref_cnt >= RW'(`SDCR_REFI_CYC));
   assign ref_lapsed = (ref_cnt >= RW'(REF_CYC));
   assign clk_change_ok = (state == sdcr_pkg::S_PDOWN) || (state == sdcr_pkg::S_STOP);
   // fifo drains only from idle, so refresh and power-down stall the source;
   // the pop must match the cycle in which idle really issues the activate,
   // or a word popped while a refresh or mode delay runs out would be lost
   assign q_ready = (state == sdcr_pkg::S_IDLE) && (wait_cnt == 12'h000) && !ref_due &&
      !clk_stop_req;

   // next-state and pin values; pins are registered so each command lasts one cycle
   always_comb
   begin
      next_state = state;
      next_wait = (wait_cnt != 12'h000) ? wait_cnt - 12'h001 : 12'h000;
      next_ref_cnt = ref_lapsed ? ref_cnt : ref_cnt + RW'(1);
      next_act_age = (act_age != 4'hf) ? act_age + 4'h1 : act_age;
      next_ref_left = ref_left;
      next_init = init_done;
      next_cur = cur;
      next_cke = 1'b1;
      next_cmd = `SDCR_CMD_NOP;
      next_ba = ba;
      next_addr = addr;
      next_dq = dq_out;
      next_oe = 1'b0;
      next_rd_pipe = {rd_pipe[`SDCR_CL-2:0], 1'b0};
      next_rd_valid = rd_pipe[`SDCR_CL-1];
      next_rd_data = rd_pipe[`SDCR_CL-1] ? dq_in : rd_data;
      unique case (state)
         // power-up pause counted down from reset
         sdcr_pkg::S_PWRUP:
            if (wait_cnt == 12'h000)
               next_state = sdcr_pkg::S_PRE_ALL;
         sdcr_pkg::S_PRE_ALL:
            if (wait_cnt == 12'h000)
            begin
               next_cmd = `SDCR_CMD_PRE;
               next_addr = 13'h0400;
               next_wait = 12'(`SDCR_RP_CYC - 1);
               next_ref_left = 2'h2;
               next_state = sdcr_pkg::S_REF;
            end
         // refresh cycle time filled with nops
         sdcr_pkg::S_REF:
            if (wait_cnt == 12'h000)
            begin
               next_cmd = `SDCR_CMD_REF;
               next_ref_cnt = '0;
               next_wait = 12'(`SDCR_RFC_CYC - 1);
               next_ref_left = ref_left - 2'h1;
               if (ref_left == 2'h1)
                  next_state = init_done ? sdcr_pkg::S_IDLE : sdcr_pkg::S_LMR;
            end
         // mode set delay leaves a nop behind
         sdcr_pkg::S_LMR:
            if (wait_cnt == 12'h000)
            begin
               next_cmd = `SDCR_CMD_LMR;
               next_ba = 2'h0;
               next_addr = `SDCR_MODE_WORD;
               next_wait = 12'(`SDCR_MRD_CYC - 1);
               next_init = 1'b1;
               next_state = sdcr_pkg::S_IDLE;
            end
         // refresh first, then clock stop, then access, then power-down
         sdcr_pkg::S_IDLE:
            if (wait_cnt == 12'h000)
            begin
               if (ref_due)
               begin
                  // a lapsed period earns the wake pair again
                  next_ref_left = ref_lapsed ? 2'h2 : 2'h1;
                  next_state = sdcr_pkg::S_REF;
               end
               else if (clk_stop_req)
               begin
                  next_cke = 1'b0;
                  next_state = sdcr_pkg::S_STOP;
               end
               else if (q_valid)
               begin
                  next_cmd = `SDCR_CMD_ACT;
                  next_cur = q_req;
                  next_ba = q_req.bank;
                  next_addr = q_req.row;
                  next_act_age = 4'h0;
                  next_wait = 12'(`SDCR_RCD_CYC - 1);
                  next_state = sdcr_pkg::S_RW;
               end
               else if (pd_req)
               begin
                  next_cke = 1'b0;
                  next_state = sdcr_pkg::S_PDOWN;
               end
            end
         sdcr_pkg::S_RW:
            if (wait_cnt == 12'h000)
            begin
               next_cmd = cur.we ? `SDCR_CMD_WR : `SDCR_CMD_RD;
               next_addr = {4'h0, cur.col};
               next_dq = cur.data;
               next_oe = cur.we;
               next_rd_pipe[0] = !cur.we;
               // write recovery: a full cycle past the last data
               next_wait = cur.we ? 12'(`SDCR_WR_CYC) : 12'h000;
               next_state = sdcr_pkg::S_PRE;
            end
         // precharge waits for recovery and row active minimum
         sdcr_pkg::S_PRE:
            if (wait_cnt == 12'h000 && act_age >= 4'(`SDCR_RAS_CYC))
            begin
               next_cmd = `SDCR_CMD_PRE;
               next_addr = 13'h0000;
               next_wait = 12'(`SDCR_RP_CYC - 1);
               next_state = sdcr_pkg::S_IDLE;
            end
         // leave power-down as soon as a refresh is due
         sdcr_pkg::S_PDOWN:
            if (pd_req && !ref_due)
               next_cke = 1'b0;
            else
               next_state = sdcr_pkg::S_IDLE;
         // device clock held off outside; refreshes may lapse here
         sdcr_pkg::S_STOP:
            if (clk_stop_req)
               next_cke = 1'b0;
            else
               next_state = sdcr_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state <= sdcr_pkg::S_PWRUP;
         wait_cnt <= 12'(`SDCR_PWRUP_CYC - 1);
         ref_cnt <= '0;
         act_age <= 4'hf;
         ref_left <= 2'h0;
         init_done <= 1'b0;
         cur <= '0;
         cke <= 1'b1;
         cmd <= `SDCR_CMD_NOP;
         ba <= 2'h0;
         addr <= 13'h0000;
         dq_out <= 16'h0000;
         dq_oe <= 1'b0;
         rd_pipe <= '0;
         rd_valid <= 1'b0;
         rd_data <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         wait_cnt <= next_wait;
         ref_cnt <= next_ref_cnt;
         act_age <= next_act_age;
         ref_left <= next_ref_left;
         init_done <= next_init;
         cur <= next_cur;
         cke <= next_cke;
         cmd <= next_cmd;
         ba <= next_ba;
         addr <= next_addr;
         dq_out <= next_dq;
         dq_oe <= next_oe;
         rd_pipe <= next_rd_pipe;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
      end
   end

   // pin-side helper counters for the checks below
   logic [12:0] boot_age;
   logic [3:0] pin_act_age;
   logic [1:0] refs_seen;
   logic is_nop, is_ref, is_pre, is_wr;
   assign is_nop = (cmd == `SDCR_CMD_NOP);
   assign is_ref = (cmd == `SDCR_CMD_REF);
   assign is_pre = (cmd == `SDCR_CMD_PRE);
   assign is_wr = (cmd == `SDCR_CMD_WR);
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         boot_age <= 13'h0000;
         pin_act_age <= 4'hf;
         refs_seen <= 2'h0;
      end
      else
      begin
         boot_age <= (boot_age != 13'h1fff) ? boot_age + 13'h0001 : boot_age;
         pin_act_age <= (cmd == `SDCR_CMD_ACT) ? 4'h1 :
            ((pin_act_age != 4'hf) ? pin_act_age + 4'h1 : pin_act_age);
         refs_seen <= (is_ref && refs_seen != 2'h3) ? refs_seen + 2'h1 : refs_seen;
      end
   end

   property p_pwrup_pause;
      @(posedge core_clk) disable iff (!rst_b) !is_nop |-> boot_age >= 13'(`SDCR_PWRUP_CYC);
   endproperty
   a_pwrup_pause: assert property (p_pwrup_pause) else $error("command before power-up pause");
   property p_two_refs;
      @(posedge core_clk) disable iff (!rst_b) $rose(init_done) |-> refs_seen == 2'h2;
   endproperty
   a_two_refs: assert property (p_two_refs) else $error("init without two refreshes");
   property p_lapse_pair;
      @(posedge core_clk) disable iff (!rst_b)
         (state == sdcr_pkg::S_IDLE && ref_lapsed && wait_cnt == 12'h000)
         |-> ##[1:3] is_ref ##[4:6] is_ref;
   endproperty
   a_lapse_pair: assert property (p_lapse_pair) else $error("lapse without refresh pair");
   property p_clk_change;
      @(posedge core_clk) disable iff (!rst_b) clk_change_ok |-> !cke;
   endproperty
   a_clk_change: assert property (p_clk_change) else $error("clock change with cke high");
   property p_rfc_nops;
      @(posedge core_clk) disable iff (!rst_b) is_ref |=> is_nop [*3];
   endproperty
   a_rfc_nops: assert property (p_rfc_nops) else $error("command inside refresh cycle");
   property p_mrd_nop;
      @(posedge core_clk) disable iff (!rst_b) (cmd == `SDCR_CMD_LMR) |=> is_nop;
   endproperty
   a_mrd_nop: assert property (p_mrd_nop) else $error("no nop after mode set");
   property p_write_recovery;
      @(posedge core_clk) disable iff (!rst_b) is_wr |=> !is_pre ##1 !dq_oe;
   endproperty
   a_write_recovery: assert property (p_write_recovery) else $error("precharge too soon");
   property p_row_active;
      @(posedge core_clk) disable iff (!rst_b)
         (is_pre && !addr[`SDCR_AP_BIT]) |-> pin_act_age >= 4'(`SDCR_RAS_CYC);
   endproperty
   a_row_active: assert property (p_row_active) else $error("row active time violated");
   property p_pd_refresh;
      @(posedge core_clk) disable iff (!rst_b)
         (state == sdcr_pkg::S_PDOWN && ref_due) |=> state == sdcr_pkg::S_IDLE ##1 cke;
   endproperty
   a_pd_refresh: assert property (p_pd_refresh) else $error("power-down hid a refresh");

   c_init: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(init_done));
   c_write: cover property (@(posedge core_clk) disable iff (!rst_b) is_wr ##[2:4] is_pre);
   c_read: cover property (@(posedge core_clk) disable iff (!rst_b) rd_valid);
   c_pdown: cover property (@(posedge core_clk) disable iff (!rst_b)
      state == sdcr_pkg::S_PDOWN ##[1:400] is_ref);
endmodule

//--- verilog/sdcr_params.svh
// timing counts, pin encodings and mode settings for the sdram host controller
`ifndef SDCR_PARAMS_SVH
`define SDCR_PARAMS_SVH
`define SDCR_CLK_MHZ 40
// least times round up, longest times round down
`define SDCR_CYC_UP(ns) ((((ns) * `SDCR_CLK_MHZ) + 999) / 1000)
`define SDCR_CYC_DN(ns) (((ns) * `SDCR_CLK_MHZ) / 1000)
`define SDCR_T_PWRUP_NS 100000
`define SDCR_PWRUP_CYC `SDCR_CYC_UP(`SDCR_T_PWRUP_NS)
`define SDCR_T_RFC_NS 80
`define SDCR_RFC_CYC `SDCR_CYC_UP(`SDCR_T_RFC_NS)
`define SDCR_MRD_CYC 2
`define SDCR_T_WR_NS 15
`define SDCR_WR_CYC `SDCR_CYC_UP(`SDCR_T_WR_NS)
`define SDCR_T_RP_NS 20
`define SDCR_RP_CYC `SDCR_CYC_UP(`SDCR_T_RP_NS)
`define SDCR_T_RAS_NS 45
`define SDCR_RAS_CYC `SDCR_CYC_UP(`SDCR_T_RAS_NS)
`define SDCR_T_RCD_NS 20
`define SDCR_RCD_CYC `SDCR_CYC_UP(`SDCR_T_RCD_NS)
`define SDCR_T_REFI_NS 7812
`define SDCR_REFI_CYC `SDCR_CYC_DN(`SDCR_T_REFI_NS)
`define SDCR_T_REF_MS 64
`define SDCR_REF_CYC (`SDCR_T_REF_MS * `SDCR_CLK_MHZ * 1000)
`define SDCR_CL 2
`define SDCR_MODE_WORD 13'h020
`define SDCR_AP_BIT 10
// command pins cs_b, ras_b, cas_b, we_b
`define SDCR_CMD_NOP 4'h7
`define SDCR_CMD_ACT 4'h3
`define SDCR_CMD_RD 4'h5
`define SDCR_CMD_WR 4'h4
`define SDCR_CMD_PRE 4'h2
`define SDCR_CMD_REF 4'h1
`define SDCR_CMD_LMR 4'h0
`endif

//--- verilog/sdcr_pkg.sv
// types shared by the sdram host controller
package sdcr_pkg;
   typedef struct packed
   {
      logic cs_b;
      logic ras_b;
      logic cas_b;
      logic we_b;
   } sdcr_cmd_s;
   typedef struct packed
   {
      logic we;
      logic [1:0] bank;
      logic [12:0] row;
      logic [8:0] col;
      logic [15:0] data;
   } sdcr_req_s;
   typedef enum logic [3:0]
   {
      S_PWRUP, S_PRE_ALL, S_REF, S_LMR, S_IDLE, S_RW, S_PRE, S_PDOWN, S_STOP
   } sdcr_state_e;
endpackage

//--- tb/sdcr_dev_model.sv
// behavioural sdram device that also counts host command timing faults
`include "sdcr_params.svh"
module sdcr_dev_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // pins from the host
   input wire logic cke,
   input wire sdcr_pkg::sdcr_cmd_s cmd,
   input wire logic [1:0] ba,
   input wire logic [12:0] addr,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe,
   // to the host and the bench
   output logic [15:0] dq_in,
   output int n_ref,
   output int n_viol
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [int];
   logic [12:0] open_row [4];
   int t, t_ref, t_lmr, t_act, t_wr;
   logic pend;
   logic [15:0] pw;
   initial dq_in = 16'h0000;
   // read data answers on the same edge that first sees the read pin, so the host's
   // sample two edges after it drove the pin catches the word
   always @(posedge core_clk)
   begin
      pend = 1'b0;
      pw = 16'h0000;
      if (!rst_b)
      begin
         t = 0;
         n_ref = 0;
         n_viol = 0;
         t_ref = -99;
         t_lmr = -99;
         t_act = -99;
         t_wr = -99;
      end
      else
      begin
         t = t + 1;
         if (cke && cmd != `SDCR_CMD_NOP)
         begin
            if (t < `SDCR_PWRUP_CYC) n_viol++;
            if (t - t_ref < `SDCR_RFC_CYC) n_viol++;
            if (t - t_lmr < `SDCR_MRD_CYC) n_viol++;
            case (cmd)
               `SDCR_CMD_REF:
               begin
                  n_ref++;
                  t_ref = t;
               end
               `SDCR_CMD_LMR: t_lmr = t;
               `SDCR_CMD_ACT:
               begin
                  if (n_ref < 2) n_viol++;
                  open_row[ba] = addr;
                  t_act = t;
               end
               `SDCR_CMD_WR:
               begin
                  // undriven data lands inverted, so a missing enable shows on readback
                  mem[{ba, open_row[ba], addr[8:0]}] = dq_oe ? dq_out : ~dq_out;
                  t_wr = t;
               end
               `SDCR_CMD_RD:
               begin
                  pw = mem[{ba, open_row[ba], addr[8:0]}];
                  pend = 1'b1;
               end
               `SDCR_CMD_PRE:
               begin
                  if (t - t_wr <= `SDCR_WR_CYC) n_viol++;
                  if (t - t_act < `SDCR_RAS_CYC) n_viol++;
               end
               default: ;
            endcase
         end
      end
      // idle data lines toggle every cycle so a stale sample never matches
      dq_in <= pend ? pw : ~dq_in;
   end
endmodule

//--- tb/tb.sv
// self-checking bench for the sdram host controller against the device model
`include "sdcr_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REF_LAPSE = 1000;
   logic core_clk, rst_b, req_valid, req_ready, rd_valid, init_done;
   logic pd_req, clk_stop_req, clk_change_ok, cke, dq_oe;
   sdcr_pkg::sdcr_req_s req;
   sdcr_pkg::sdcr_cmd_s cmd;
   logic [15:0] rd_data, dq_out, dq_in;
   logic [1:0] ba;
   logic [12:0] addr;
   int n_fail, compares, n_ref, n_viol, r0;
   logic [15:0] shadow [int];
   logic [15:0] exp_q [$];
   int keys [$];

   sdcr_ctrl #(.REF_CYC(REF_LAPSE), .FIFO_DEPTH(16)) DUT (.core_clk(core_clk), .rst_b(rst_b),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .init_done(init_done), .pd_req(pd_req),
      .clk_stop_req(clk_stop_req), .clk_change_ok(clk_change_ok), .cke(cke), .cmd(cmd),
      .ba(ba), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
   sdcr_dev_model dev (.core_clk(core_clk), .rst_b(rst_b), .cke(cke), .cmd(cmd), .ba(ba),
      .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .n_ref(n_ref),
      .n_viol(n_viol));

   // 40 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic bad(input string msg);
      n_fail++;
      $display("ERROR %0t %s", $time, msg);
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) bad($sformatf("read word %h expected %h", got, exp));
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) bad($sformatf("count %0d outside %0d..%0d", got, lo, hi));
   endtask
   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // valid stays high between calls so requests go back to back
   task automatic send(input logic we, input int k, input logic [15:0] d);
      int n;
      @(negedge core_clk);
      req_valid = 1'b1;
      req = '{we, k[23:22], k[21:9], k[8:0], d};
      n = 0;
      while (req_ready !== 1'b1 && n < 3000)
      begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 3000) bad("request never taken");
      if (we) shadow[k] = d;
      else exp_q.push_back(shadow[k]);
      @(posedge core_clk);
   endtask
   task automatic wait_flag(ref logic f, input logic v);
      for (int i = 0; i < 6000 && f !== v; i++) @(negedge core_clk);
      if (f !== v) bad("flag wait expired");
   endtask
   task automatic drain();
      @(negedge core_clk);
      req_valid = 1'b0;
      for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge core_clk);
      chk_cnt(exp_q.size(), 0, 0);
   endtask

   // read results are judged against the oldest note in the queue
   always @(negedge core_clk)
      if (rd_valid === 1'b1)
         chk_word(rd_data, exp_q.pop_front());

   initial
   begin
      #(25ns * 20000);
      bad("watchdog expired");
      summarize();
   end

   initial
   begin
      rst_b = 1'b0;
      req_valid = 1'b0;
      req = '0;
      pd_req = 1'b0;
      clk_stop_req = 1'b0;
      r0 = $urandom(32'h958b);
      repeat (5) @(negedge core_clk);
      chk_bit(cke, 1'b1);
      chk_bit(cmd == `SDCR_CMD_NOP, 1'b1);
      chk_bit(init_done, 1'b0);
      rst_b = 1'b1;
      wait_flag(init_done, 1'b1);
      chk_bit(init_done, 1'b1);
      chk_cnt(n_ref, 2, 2);
      $display("test wake done");
      // random words written and read back to back
      for (int i = 0; i < 12; i++)
      begin
         keys.push_back(24'($urandom));
         send(1'b1, keys[i], 16'($urandom));
      end
      foreach (keys[i]) send(1'b0, keys[i], 16'h0000);
      drain();
      $display("test access done");
      // clock stop stalls the buffer; a lapse must bring the refresh pair
      @(negedge core_clk);
      clk_stop_req = 1'b1;
      wait_flag(cke, 1'b0);
      chk_bit(clk_change_ok, 1'b1);
      keys.delete();
      for (int i = 0; i < 16; i++)
      begin
         keys.push_back(24'($urandom));
         send(1'b1, keys[i], 16'($urandom));
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      chk_bit(req_ready, 1'b0);
      repeat (REF_LAPSE) @(negedge core_clk);
      r0 = n_ref;
      clk_stop_req = 1'b0;
      repeat (40) @(negedge core_clk);
      chk_cnt(n_ref - r0, 2, 3);
      chk_bit(clk_change_ok, 1'b0);
      foreach (keys[i]) send(1'b0, keys[i], 16'h0000);
      drain();
      $display("test stop done");
      // power-down must still leave for refresh
      pd_req = 1'b1;
      wait_flag(cke, 1'b0);
      chk_bit(clk_change_ok, 1'b1);
      r0 = n_ref;
      repeat (1000) @(negedge core_clk);
      chk_cnt(n_ref - r0, 3, 4);
      pd_req = 1'b0;
      $display("test power-down done");
      // idle refreshes spread out one by one
      r0 = n_ref;
      repeat (1000) @(negedge core_clk);
      chk_cnt(n_ref - r0, 3, 4);
      chk_cnt(n_viol, 0, 0);
      $display("test refresh done");
      summarize();
   end
endmodule
